// ---- verilog/pmoc_pkg.sv ----
// Constants and types of the power on/off and margin control block
// Function
// - Enable field 00 shuts the output down at once, no sequencing.
// - Enable field 01 performs a soft, sequenced shutdown.
// - Enable field 10 turns on at the selected margin state.
// - Margin field 00 selects the nominal output target.
// - Margin field 01 selects margin low, 10 selects margin high.
// - Fault handling 01 ignores output over/under voltage events while margined.
// - Fault handling 10 acts on output over/under voltage events while margined.
// - Config bit 4 clear: run whenever input power is present.
// - Config bit 4 set: stay off until enabled sources command start.
// - Config bit 3 clear: ignore the bus on/off field.
// - Config bit 3 set: start only when the bus field requests running.
// - Config bit 2 clear: ignore the on/off pin.
// - Config bit 2 set: start only while the pin is asserted.
// - Config bit 1 sets pin polarity: 0 high asserted, 1 low asserted.
// - Config bit 0 clear: pin turn-off uses the sequenced soft shutdown.
// - Config bit 0 set: pin turn-off stops energy transfer at once.
// - Clear-faults command resets every fault status bit.
// - Restore-default command reloads the whole configuration from defaults.
// - Store-user command saves every setting changed since the last restore.
// - Restore-user command, and every power up, reload the user store.
package pmoc_pkg;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_RESTORE_DEF = 8'h12;
    localparam logic [7:0] CMD_STORE_USER = 8'h15;
    localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
    localparam logic [1:0] FIELD_RSVD = 2'h3;
    localparam logic [1:0] EN_IMM_OFF = 2'h0;
    localparam logic [1:0] EN_SOFT_OFF = 2'h1;
    localparam logic [1:0] EN_ON = 2'h2;
    localparam logic [1:0] MG_NOMINAL = 2'h0;
    localparam logic [1:0] MG_LOW = 2'h1;
    localparam logic [1:0] MG_HIGH = 2'h2;
    localparam logic [1:0] FH_IGNORE = 2'h1;
    localparam logic [1:0] FH_ACT = 2'h2;
    localparam logic [7:0] OP_RESET = 8'h88;
    localparam logic [7:0] ON_OFF_RESET = 8'h16;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // Operation byte, msb first
    typedef struct packed {
        logic [1:0] en;
        logic [1:0] mg;
        logic [1:0] fh;
        logic [1:0] rsv;
    } pmoc_op_type;
    // Start source configuration byte, msb first
    typedef struct packed {
        logic [2:0] rsv;
        logic powerup;
        logic use_bus;
        logic use_pin;
        logic pin_low;
        logic fast_off;
    } pmoc_onoff_type;
    typedef struct packed {
        pmoc_op_type op;
        pmoc_onoff_type onoff;
    } pmoc_cfg_type;
    localparam pmoc_cfg_type CFG_DEFAULT = {OP_RESET, ON_OFF_RESET};
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_AACK = 4'h2,
        S_CMD = 4'h3,
        S_CACK = 4'h4,
        S_DATA = 4'h5,
        S_DACK = 4'h6,
        S_RD = 4'h7,
        S_RACK = 4'h8
    } pmoc_bus_state_type;
endpackage : pmoc_pkg

// ---- verilog/pmoc_ctrl.sv ----
// Power on/off and margin control with its serial command slave
`timescale 1ns/1ps
module pmoc_ctrl #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic ctrl_pin,
    input wire logic power_ok,
    output logic run,
    output logic stop_fast,
    output logic stop_soft,
    output logic [1:0] margin_sel,
    output logic vout_fault_ignore,
    output logic fault_clear
);
    // ------------------------------------------------------------
    // Input synchronisers and bus edges
    // ------------------------------------------------------------
    logic [1:0] scl_sync_reg, sda_sync_reg, pin_sync_reg, pwr_sync_reg;
    logic scl_d_reg, sda_d_reg;
    logic scl_s, sda_s, pin_s, pwr_s;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            pin_sync_reg <= 2'h0;
            pwr_sync_reg <= 2'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            pin_sync_reg <= {pin_sync_reg[0], ctrl_pin};
            pwr_sync_reg <= {pwr_sync_reg[0], power_ok};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign pin_s = pin_sync_reg[1];
    assign pwr_s = pwr_sync_reg[1];
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_cond = scl_s && scl_d_reg && !sda_s && sda_d_reg;
    assign stop_cond = scl_s && scl_d_reg && sda_s && !sda_d_reg;

    // ------------------------------------------------------------
    // Serial command slave
    // ------------------------------------------------------------
    pmoc_pkg::pmoc_bus_state_type st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] cmd_reg, cmd_next;
    logic rw_reg, rw_next;
    logic sda_oe_n_reg, sda_oe_n_next;
    logic sda_o_reg;
    logic cmd_ev, wr_ev;
    logic [7:0] rd_value;
    pmoc_pkg::pmoc_cfg_type cfg_reg, cfg_next;

    always_comb begin
        case (cmd_reg)
            pmoc_pkg::CMD_OPERATION: rd_value = cfg_reg.op;
            pmoc_pkg::CMD_ON_OFF: rd_value = cfg_reg.onoff;
            default: rd_value = 8'h00;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        cmd_next = cmd_reg;
        rw_next = rw_reg;
        sda_oe_n_next = sda_oe_n_reg;
        cmd_ev = 1'b0;
        wr_ev = 1'b0;
        if (start_cond) begin
            st_next = pmoc_pkg::S_ADDR;
            cnt_next = 4'h0;
            sda_oe_n_next = 1'b1;
        end else if (stop_cond) begin
            st_next = pmoc_pkg::S_IDLE;
            sda_oe_n_next = 1'b1;
        end else if (scl_rise) begin
            case (st_reg)
                pmoc_pkg::S_ADDR, pmoc_pkg::S_CMD, pmoc_pkg::S_DATA: begin
                    sh_next = {sh_reg[6:0], sda_s};
                    cnt_next = cnt_reg + 4'h1;
                end
                pmoc_pkg::S_RACK: st_next = pmoc_pkg::S_IDLE;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (st_reg)
                pmoc_pkg::S_ADDR: begin
                    if (cnt_reg == pmoc_pkg::BYTE_BITS) begin
                        if (sh_reg[7:1] == DEV_ADDR) begin
                            sda_oe_n_next = 1'b0;
                            rw_next = sh_reg[0];
                            st_next = pmoc_pkg::S_AACK;
                        end else begin
                            st_next = pmoc_pkg::S_IDLE;
                        end
                    end
                end
                pmoc_pkg::S_AACK: begin
                    cnt_next = 4'h0;
                    if (rw_reg) begin
                        tx_next = rd_value;
                        sda_oe_n_next = rd_value[7];
                        st_next = pmoc_pkg::S_RD;
                    end else begin
                        sda_oe_n_next = 1'b1;
                        st_next = pmoc_pkg::S_CMD;
                    end
                end
                pmoc_pkg::S_CMD: begin
                    if (cnt_reg == pmoc_pkg::BYTE_BITS) begin
                        cmd_next = sh_reg;
                        cmd_ev = 1'b1;
                        sda_oe_n_next = 1'b0;
                        st_next = pmoc_pkg::S_CACK;
                    end
                end
                pmoc_pkg::S_DATA: begin
                    if (cnt_reg == pmoc_pkg::BYTE_BITS) begin
                        wr_ev = 1'b1;
                        sda_oe_n_next = 1'b0;
                        st_next = pmoc_pkg::S_DACK;
                    end
                end
                pmoc_pkg::S_CACK, pmoc_pkg::S_DACK: begin
                    cnt_next = 4'h0;
                    sda_oe_n_next = 1'b1;
                    st_next = pmoc_pkg::S_DATA;
                end
                pmoc_pkg::S_RD: begin
                    if (cnt_reg == pmoc_pkg::LAST_BIT) begin
                        sda_oe_n_next = 1'b1;
                        st_next = pmoc_pkg::S_RACK;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                        tx_next = {tx_reg[6:0], 1'b0};
                        sda_oe_n_next = tx_reg[6];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= pmoc_pkg::S_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            cmd_reg <= 8'h00;
            rw_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            sda_o_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            cmd_reg <= cmd_next;
            rw_reg <= rw_next;
            sda_oe_n_reg <= sda_oe_n_next;
            sda_o_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration, user store and store commands
    // ------------------------------------------------------------
    pmoc_pkg::pmoc_cfg_type user_reg, user_next;
    pmoc_pkg::pmoc_op_type op_w;
    logic [1:0] dirty_reg, dirty_next;
    logic boot_reg;
    logic clr_reg, clr_next;

    always_comb begin
        cfg_next = cfg_reg;
        user_next = user_reg;
        dirty_next = dirty_reg;
        clr_next = 1'b0;
        op_w = pmoc_pkg::pmoc_op_type'(sh_reg);
        if (boot_reg) begin
            cfg_next = user_reg;
            dirty_next = 2'h0;
        end else if (cmd_ev) begin
            case (sh_reg)
                pmoc_pkg::CMD_CLEAR_FAULTS: clr_next = 1'b1;
                pmoc_pkg::CMD_RESTORE_DEF: begin
                    cfg_next = pmoc_pkg::CFG_DEFAULT;
                    dirty_next = 2'h0;
                end
                pmoc_pkg::CMD_STORE_USER: begin
                    if (dirty_reg[1]) begin
                        user_next.op = cfg_reg.op;
                    end
                    if (dirty_reg[0]) begin
                        user_next.onoff = cfg_reg.onoff;
                    end
                end
                pmoc_pkg::CMD_RESTORE_USER: begin
                    cfg_next = user_reg;
                    dirty_next = 2'h0;
                end
                default: ;
            endcase
        end else if (wr_ev) begin
            if (cmd_reg == pmoc_pkg::CMD_OPERATION) begin
                dirty_next[1] = 1'b1;
                cfg_next.op.rsv = op_w.rsv;
                if (op_w.en != pmoc_pkg::FIELD_RSVD) begin
                    cfg_next.op.en = op_w.en;
                end
                if (op_w.mg != pmoc_pkg::FIELD_RSVD) begin
                    cfg_next.op.mg = op_w.mg;
                end
                if (op_w.fh != pmoc_pkg::FIELD_RSVD) begin
                    cfg_next.op.fh = op_w.fh;
                end
            end else if (cmd_reg == pmoc_pkg::CMD_ON_OFF) begin
                dirty_next[0] = 1'b1;
                cfg_next.onoff = pmoc_pkg::pmoc_onoff_type'(sh_reg);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= pmoc_pkg::CFG_DEFAULT;
            user_reg <= pmoc_pkg::CFG_DEFAULT;
            dirty_reg <= 2'h0;
            boot_reg <= 1'b1;
            clr_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            user_reg <= user_next;
            dirty_reg <= dirty_next;
            boot_reg <= 1'b0;
            clr_reg <= clr_next;
        end
    end

    // ------------------------------------------------------------
    // Run decision, shutdown style and margin
    // ------------------------------------------------------------
    logic pin_act, bus_ok, pin_ok, want_run, fast_cut;
    logic run_reg, run_next;
    logic fast_reg, fast_next;
    logic soft_reg, soft_next;
    logic [1:0] margin_reg, margin_next;
    logic ignore_reg, ignore_next;

    always_comb begin
        pin_act = pin_s ^ cfg_reg.onoff.pin_low;
        bus_ok = !cfg_reg.onoff.use_bus || (cfg_reg.op.en == pmoc_pkg::EN_ON);
        pin_ok = !cfg_reg.onoff.use_pin || pin_act;
        want_run = pwr_s && (!cfg_reg.onoff.powerup || (bus_ok && pin_ok));
        fast_cut = !pwr_s
            || (cfg_reg.onoff.powerup && cfg_reg.onoff.use_pin && !pin_act
                && cfg_reg.onoff.fast_off)
            || (cfg_reg.onoff.powerup && cfg_reg.onoff.use_bus
                && cfg_reg.op.en == pmoc_pkg::EN_IMM_OFF);
        run_next = want_run;
        fast_next = fast_reg;
        soft_next = soft_reg;
        if (want_run) begin
            fast_next = 1'b0;
            soft_next = 1'b0;
        end else if (run_reg) begin
            fast_next = fast_cut;
            soft_next = !fast_cut;
        end
        margin_next = cfg_reg.op.mg;
        ignore_next = (cfg_reg.op.mg != pmoc_pkg::MG_NOMINAL)
            && (cfg_reg.op.fh == pmoc_pkg::FH_IGNORE);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_reg <= 1'b0;
            fast_reg <= 1'b0;
            soft_reg <= 1'b0;
            margin_reg <= pmoc_pkg::MG_NOMINAL;
            ignore_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            fast_reg <= fast_next;
            soft_reg <= soft_next;
            margin_reg <= margin_next;
            ignore_reg <= ignore_next;
        end
    end

    assign sda_o = sda_o_reg;
    assign sda_oe_n = sda_oe_n_reg;
    assign run = run_reg;
    assign stop_fast = fast_reg;
    assign stop_soft = soft_reg;
    assign margin_sel = margin_reg;
    assign vout_fault_ignore = ignore_reg;
    assign fault_clear = clr_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_bus_imm_off: assert property (run_reg && pwr_s && cfg_reg.onoff.powerup
        && cfg_reg.onoff.use_bus && cfg_reg.op.en == pmoc_pkg::EN_IMM_OFF
        |=> !run_reg && fast_reg && !soft_reg) else $error("bus immediate off failed");
    a_bus_soft_off: assert property (run_reg && pwr_s && cfg_reg.onoff.powerup
        && cfg_reg.onoff.use_bus && cfg_reg.op.en == pmoc_pkg::EN_SOFT_OFF
        && !(cfg_reg.onoff.use_pin && !pin_act && cfg_reg.onoff.fast_off)
        |=> !run_reg && soft_reg && !fast_reg) else $error("bus soft off failed");
    a_pin_off_style: assert property (run_reg && pwr_s && cfg_reg.onoff.powerup
        && cfg_reg.onoff.use_pin && !pin_act
        && !(cfg_reg.onoff.use_bus && cfg_reg.op.en == pmoc_pkg::EN_IMM_OFF)
        |=> !run_reg && fast_reg == $past(cfg_reg.onoff.fast_off))
        else $error("pin off style wrong");
    a_margin_follow: assert property ($stable(cfg_reg.op.mg) [*2]
        |-> margin_reg == cfg_reg.op.mg) else $error("margin select mismatch");
    a_fault_ignore: assert property (ignore_reg
        |-> $past(cfg_reg.op.fh) == pmoc_pkg::FH_IGNORE
        && $past(cfg_reg.op.mg) != pmoc_pkg::MG_NOMINAL) else $error("fault ignore wrong");
    a_always_on: assert property ((pwr_s && !cfg_reg.onoff.powerup) [*2]
        |-> run_reg) else $error("always on not running");
    a_pin_gate: assert property (run_reg && $past(cfg_reg.onoff.powerup)
        && $past(cfg_reg.onoff.use_pin) |-> $past(pin_act)) else $error("run without pin");
    a_bus_gate: assert property (run_reg && $past(cfg_reg.onoff.powerup)
        && $past(cfg_reg.onoff.use_bus) |-> $past(cfg_reg.op.en) == pmoc_pkg::EN_ON)
        else $error("run without bus enable");
    a_clear_pulse: assert property (cmd_ev && sh_reg == pmoc_pkg::CMD_CLEAR_FAULTS
        |=> fault_clear ##1 !fault_clear) else $error("clear faults pulse wrong");
    a_restore_def: assert property (cmd_ev && sh_reg == pmoc_pkg::CMD_RESTORE_DEF
        |=> cfg_reg == pmoc_pkg::CFG_DEFAULT) else $error("default restore failed");
    a_powerup_user: assert property (boot_reg |=> cfg_reg == $past(user_reg))
        else $error("power up restore failed");
    a_reserved_keep: assert property (wr_ev && cmd_reg == pmoc_pkg::CMD_OPERATION
        && sh_reg[7:6] == pmoc_pkg::FIELD_RSVD |=> $stable(cfg_reg.op.en))
        else $error("reserved enable changed state");

    c_run_on: cover property ($rose(run_reg));
    c_soft_off: cover property ($rose(soft_reg));
    c_read_back: cover property (st_reg == pmoc_pkg::S_RD ##[1:300] st_reg == pmoc_pkg::S_RACK);
    c_store_user: cover property (cmd_ev && sh_reg == pmoc_pkg::CMD_STORE_USER);
endmodule : pmoc_ctrl

// ---- verif/pmoc_host.sv ----
// Bus host model driving the serial clock and data lines
`timescale 1ns/1ps
module pmoc_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    // ----------------------------------------
    // Line timing, four clocks per clock phase
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    // Data changes one clock into the low phase
    task automatic bit_x(input logic b, output logic r);
        wt(1);
        sda_m <= b;
        wt(3);
        scl <= 1'b1;
        wt(2);
        r = sda;
        wt(2);
        scl <= 1'b0;
    endtask : bit_x

    // Also serves as repeated start
    task automatic start;
        wt(1);
        sda_m <= 1'b1;
        wt(3);
        scl <= 1'b1;
        wt(4);
        sda_m <= 1'b0;
        wt(4);
        scl <= 1'b0;
    endtask : start

    task automatic stop;
        wt(1);
        sda_m <= 1'b0;
        wt(3);
        scl <= 1'b1;
        wt(4);
        sda_m <= 1'b1;
        wt(4);
    endtask : stop

    // Eight bits msb first, then the acknowledge slot released
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : byte_x

    // Mode 0 send byte, 1 write byte, 2 read byte
    task automatic frame(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                         input int mode, output logic [7:0] q, output logic [2:0] acks);
        logic [7:0] junk;
        logic k;
        acks = 3'h0;
        q = 8'h00;
        start();
        byte_x({a, 1'b0}, junk, k);
        acks = acks + {2'h0, k};
        byte_x(c, junk, k);
        acks = acks + {2'h0, k};
        if (mode == 1) begin
            byte_x(d, junk, k);
            acks = acks + {2'h0, k};
        end
        if (mode == 2) begin
            start();
            byte_x({a, 1'b1}, junk, k);
            acks = acks + {2'h0, k};
            byte_x(8'hFF, q, k);
        end
        stop();
    endtask : frame
endmodule : pmoc_host

// ---- verif/tb_top.sv ----
// Self-checking bench of the power on/off and margin control block
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] DEV = 7'h2A; // Arbitrary bus address
    logic clk, nrst, ctrl_pin, power_ok, scl, sda_m, sda, sda_o, sda_oe_n;
    logic run, stop_fast, stop_soft, vout_fault_ignore, fault_clear;
    logic [1:0] margin_sel;
    logic [7:0] stat;
    int failures, checks_done, clear_count;

    assign sda = sda_m & (sda_oe_n | sda_o);
    assign stat = {2'h0, margin_sel, vout_fault_ignore, stop_soft, stop_fast, run};

    pmoc_ctrl #(.DEV_ADDR(DEV)) dut (.clk(clk), .nrst(nrst), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .ctrl_pin(ctrl_pin), .power_ok(power_ok),
        .run(run), .stop_fast(stop_fast), .stop_soft(stop_soft), .margin_sel(margin_sel),
        .vout_fault_ignore(vout_fault_ignore), .fault_clear(fault_clear));
    pmoc_host host (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    always @(negedge clk) begin
        if (fault_clear === 1'b1) clear_count++;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Status: margin[5:4] ignore[3] soft[2] fast[1] run[0]
    task automatic expect_st(input logic [7:0] exp);
        // Settle first, so an unchanged expectation is judged too
        repeat (6) @(negedge clk);
        for (int i = 0; i < 12 && stat !== exp; i++) @(negedge clk);
        chk("outputs", exp, stat);
    endtask : expect_st

    task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                        input int mode, input logic [2:0] acks, input logic [7:0] q);
        logic [7:0] got;
        logic [2:0] n;
        host.frame(a, c, d, mode, got, n);
        chk("acks", {5'h00, acks}, {5'h00, n});
        if (mode == 2) chk("read data", q, got);
    endtask : xfer

    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        xfer(DEV, c, d, 1, 3'h3, 8'h00);
    endtask : wr

    task automatic rd(input logic [7:0] c, input logic [7:0] q);
        xfer(DEV, c, 8'h00, 2, 3'h3, q);
    endtask : rd

    task automatic send(input logic [7:0] c);
        xfer(DEV, c, 8'h00, 0, 3'h2, 8'h00);
    endtask : send

    task automatic drive(input logic p, input logic pw);
        @(posedge clk);
        ctrl_pin <= p;
        power_ok <= pw;
    endtask : drive

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up;
        expect_st(8'h01);
        rd(pmoc_pkg::CMD_OPERATION, 8'h88);
        rd(pmoc_pkg::CMD_ON_OFF, 8'h16);
        drive(1'b1, 1'b1);
        expect_st(8'h04);
        drive(1'b0, 1'b1);
        expect_st(8'h01);
        $display("done power_up");
    endtask : t_power_up

    task automatic t_margin;
        logic [7:0] ops [6] = '{8'h88, 8'h98, 8'h94, 8'hA4, 8'h84, 8'hA8};
        logic [7:0] exps [6] = '{8'h01, 8'h11, 8'h19, 8'h29, 8'h01, 8'h21};
        for (int i = 0; i < 6; i++) begin
            wr(pmoc_pkg::CMD_OPERATION, ops[i]);
            expect_st(exps[i]);
        end
        $display("done margin");
    endtask : t_margin

    task automatic t_reserved;
        wr(pmoc_pkg::CMD_OPERATION, 8'hFC);
        expect_st(8'h21);
        rd(pmoc_pkg::CMD_OPERATION, 8'hA8);
        wr(pmoc_pkg::CMD_OPERATION, 8'hB4);
        expect_st(8'h29);
        rd(pmoc_pkg::CMD_OPERATION, 8'hA4);
        $display("done reserved");
    endtask : t_reserved

    task automatic t_bus;
        wr(pmoc_pkg::CMD_ON_OFF, 8'h1E);
        expect_st(8'h29);
        wr(pmoc_pkg::CMD_OPERATION, 8'h44);
        expect_st(8'h04);
        wr(pmoc_pkg::CMD_OPERATION, 8'h88);
        expect_st(8'h01);
        drive(1'b1, 1'b1);
        expect_st(8'h04);
        drive(1'b0, 1'b1);
        expect_st(8'h01);
        wr(pmoc_pkg::CMD_OPERATION, 8'h08);
        expect_st(8'h02);
        wr(pmoc_pkg::CMD_ON_OFF, 8'h16);
        expect_st(8'h01);
        $display("done bus_enable");
    endtask : t_bus

    task automatic t_pin;
        wr(pmoc_pkg::CMD_ON_OFF, 8'h15);
        expect_st(8'h02);
        drive(1'b1, 1'b1);
        expect_st(8'h01);
        drive(1'b0, 1'b1);
        expect_st(8'h02);
        wr(pmoc_pkg::CMD_ON_OFF, 8'h10);
        expect_st(8'h01);
        wr(pmoc_pkg::CMD_ON_OFF, 8'h00);
        drive(1'b1, 1'b1);
        expect_st(8'h01);
        drive(1'b1, 1'b0);
        expect_st(8'h02);
        drive(1'b1, 1'b1);
        expect_st(8'h01);
        $display("done pin_control");
    endtask : t_pin

    task automatic t_faults;
        clear_count = 0;
        send(8'h40);
        send(pmoc_pkg::CMD_CLEAR_FAULTS);
        chk("clear pulses", 8'h01, clear_count[7:0]);
        $display("done clear_faults");
    endtask : t_faults

    task automatic t_store;
        wr(pmoc_pkg::CMD_OPERATION, 8'h98);
        send(pmoc_pkg::CMD_STORE_USER);
        wr(pmoc_pkg::CMD_OPERATION, 8'hA8);
        expect_st(8'h21);
        send(pmoc_pkg::CMD_RESTORE_USER);
        expect_st(8'h11);
        rd(pmoc_pkg::CMD_OPERATION, 8'h98);
        rd(pmoc_pkg::CMD_ON_OFF, 8'h00);
        send(pmoc_pkg::CMD_RESTORE_DEF);
        rd(pmoc_pkg::CMD_OPERATION, 8'h88);
        rd(pmoc_pkg::CMD_ON_OFF, 8'h16);
        expect_st(8'h04);
        rd(8'h40, 8'h00);
        xfer(7'h11, pmoc_pkg::CMD_OPERATION, 8'h08, 1, 3'h0, 8'h00);
        rd(pmoc_pkg::CMD_OPERATION, 8'h88);
        wr(pmoc_pkg::CMD_OPERATION, 8'h84);
        send(pmoc_pkg::CMD_STORE_USER);
        send(pmoc_pkg::CMD_RESTORE_USER);
        rd(pmoc_pkg::CMD_ON_OFF, 8'h00);
        rd(pmoc_pkg::CMD_OPERATION, 8'h84);
        expect_st(8'h01);
        $display("done store_restore");
    endtask : t_store

    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        failures = 0;
        checks_done = 0;
        clear_count = 0;
        nrst = 1'b0;
        ctrl_pin = 1'b0;
        power_ok = 1'b1;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_power_up();
        t_margin();
        t_reserved();
        t_bus();
        t_pin();
        t_faults();
        t_store();
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule : tb_top
